// ==== avo_pkg.sv ====
// package: constants, types and register map of the analog value operators
// Notes on behaviour
// (RULE_01) below threshold gives comparator output zero
// (RULE_02) at or above threshold gives output one
// (RULE_03) hysteresis comes from upstream, never stored
// (RULE_04) window mode: high/low thresholds, in-window outputs one
// (RULE_05) above high or below low-hyst: out-of-window
// (RULE_06) in-window holds within high and low-hyst
// (RULE_07) out-of-window holds above high-hyst or below low
// (RULE_08) enter in-window between low and high-hyst
// (RULE_09) above threshold: over, held until below thresh-hyst
// (RULE_10) below thresh-hyst: under, held until above thresh
// (RULE_11) sum mode adds two to eight inputs
// (RULE_12) difference mode: magnitude of first minus second
// (RULE_13) sign zero when positive, one when negative
// (RULE_14) averaging with sum gives the arithmetic mean
// (RULE_15) equality one when within allowed error
// (RULE_16) force-false on input anomaly holds equality zero
// (RULE_17) once per scan, registered, reset to under/out
package avo_pkg;
	localparam int MEAS_W = 16; // measurement width
	localparam int SUM_W = 19; // eight summed measurements
	localparam int CMP_W = 18; // signed compare width
	localparam int NUM_IN = 8; // arithmetic inputs
	localparam int ADDR_W = 8; // register address width
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_THRESH = 8'h04;
	localparam logic [7:0] OFS_HIGH = 8'h08;
	localparam logic [7:0] OFS_LOW = 8'h0C;
	localparam logic [7:0] OFS_TOL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_RESULT = 8'h18;
	// control field positions
	localparam int CTRL_WIN = 0;
	localparam int CTRL_DIFF = 1;
	localparam int CTRL_AVG = 2;
	localparam int CTRL_FORCE = 3;
	localparam int CTRL_CNT_LO = 4;
	localparam int CTRL_CNT_HI = 7;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h20;
	localparam logic [15:0] THRESH_RST = 16'h0000;
	localparam logic [15:0] TOL_RST = 16'h0000;
	localparam logic [3:0] CNT_MIN = 4'h2;
	localparam logic [3:0] CNT_MAX = 4'h8;
	// comparator states, gray along under/over/out/in
	typedef enum logic [1:0] {
		AVO_UNDER = 2'b00,
		AVO_OVER = 2'b01,
		AVO_OUTWIN = 2'b11,
		AVO_INWIN = 2'b10
	} avo_cmp_state_t;
	// measurements from upstream blocks
	typedef struct packed {
		logic [NUM_IN-1:0][MEAS_W-1:0] value; // value[0] first_measurement
		logic [NUM_IN-1:0] anomaly; // full-scale flag per input
		logic [MEAS_W-1:0] hysteresis; // upstream hysteresis
	} avo_meas_t;
	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wrData;
		logic wr;
		logic rd;
	} avo_bus_t;
endpackage : avo_pkg

// ==== analog_value_operators.sv ====
// module: comparator, math unit and equality checker with register port
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module analog_value_operators import avo_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire avo_bus_t bus,
	input wire avo_meas_t meas,
	output logic [31:0] rdData,
	output logic cmpOut,
	output logic [SUM_W-1:0] mathResult,
	output logic mathSign,
	output logic eqOut
);

	// absolute difference of two measurements
	function automatic logic [MEAS_W-1:0] avoAbsDiff(
		input logic [MEAS_W-1:0] a,
		input logic [MEAS_W-1:0] b
	);
		avoAbsDiff = (a >= b) ? (a - b) : (b - a);
	endfunction : avoAbsDiff

	// widen to signed compare width
	function automatic logic signed [CMP_W-1:0] avoWide(
		input logic [MEAS_W-1:0] v
	);
		avoWide = signed'({2'b00, v});
	endfunction : avoWide

	// pull a widened threshold down by the hysteresis, may go negative
	function automatic logic signed [CMP_W-1:0] avoLessHyst(
		input logic signed [CMP_W-1:0] v,
		input logic signed [CMP_W-1:0] h
	);
		avoLessHyst = v - h;
	endfunction : avoLessHyst

	// configuration registers
	logic [7:0] ctrl; // mode bits and input count
	logic [MEAS_W-1:0] thresh; // single threshold
	logic [MEAS_W-1:0] highTh; // window high threshold
	logic [MEAS_W-1:0] lowTh; // window low threshold
	logic [MEAS_W-1:0] tol; // allowed equality error
	avo_cmp_state_t state; // comparator state
	avo_cmp_state_t next_state; // comparator next state

	// decoded control bits
	wire logic windowEn = ctrl[CTRL_WIN];
	wire logic diffMode = ctrl[CTRL_DIFF];
	wire logic avgMode = ctrl[CTRL_AVG];
	wire logic forceFalse = ctrl[CTRL_FORCE];
	wire logic [3:0] cntRaw = ctrl[CTRL_CNT_HI:CTRL_CNT_LO];
	// input count clamped to two..eight
	wire logic [3:0] cnt = (cntRaw < CNT_MIN) ? CNT_MIN :
		(cntRaw > CNT_MAX) ? CNT_MAX : cntRaw;

	// bus decode
	wire logic selCtrl = bus.addr == OFS_CTRL;
	wire logic selThresh = bus.addr == OFS_THRESH;
	wire logic selHigh = bus.addr == OFS_HIGH;
	wire logic selLow = bus.addr == OFS_LOW;
	wire logic selTol = bus.addr == OFS_TOL;
	wire logic selStatus = bus.addr == OFS_STATUS;
	wire logic selResult = bus.addr == OFS_RESULT;

	// compare operands, hysteresis taken live from upstream
	wire logic signed [CMP_W-1:0] m = avoWide(meas.value[0]);
	wire logic signed [CMP_W-1:0] hy = avoWide(meas.hysteresis); // RULE_03
	wire logic signed [CMP_W-1:0] th = avoWide(thresh);
	wire logic signed [CMP_W-1:0] hi = avoWide(highTh);
	wire logic signed [CMP_W-1:0] lo = avoWide(lowTh);

	// thresholds less hysteresis, signed so small values stay low
	wire logic signed [CMP_W-1:0] thLessHy = avoLessHyst(th, hy);
	wire logic signed [CMP_W-1:0] hiLessHy = avoLessHyst(hi, hy);
	wire logic signed [CMP_W-1:0] loLessHy = avoLessHyst(lo, hy);

	// threshold crossings
	wire logic atOrOver = m >= th; // RULE_02
	wire logic belowHyst = m < thLessHy; // RULE_10
	wire logic leaveWin = (m > hi) || (m < loLessHy); // RULE_05
	wire logic enterWin = (m >= lo) && (m <= hiLessHy); // RULE_08

	// comparator next state, one step per scan
	always_comb begin
		next_state = state;
		unique case (state)
			AVO_UNDER: begin
				// leave the threshold pair when window mode arrives
				if (windowEn) begin
					next_state = AVO_OUTWIN;
				end else if (atOrOver) begin
					next_state = AVO_OVER; // RULE_09
				end else begin
					// below threshold the output stays low
					next_state = AVO_UNDER; // RULE_01
				end
			end
			AVO_OVER: begin
				// hysteresis keeps the output high near threshold
				if (windowEn) begin
					next_state = AVO_OUTWIN;
				end else if (belowHyst) begin
					next_state = AVO_UNDER; // RULE_10
				end else begin
					next_state = AVO_OVER; // RULE_09
				end
			end
			AVO_OUTWIN: begin
				// back to single threshold when window mode drops
				if (!windowEn) begin
					next_state = AVO_UNDER;
				end else if (enterWin) begin
					next_state = AVO_INWIN; // RULE_08
				end else begin
					// above high less hysteresis or below low: stay out
					next_state = AVO_OUTWIN; // RULE_07
				end
			end
			AVO_INWIN: begin
				// in-window holds between low less hysteresis and high
				if (!windowEn) begin
					next_state = AVO_UNDER;
				end else if (leaveWin) begin
					next_state = AVO_OUTWIN; // RULE_05
				end else begin
					next_state = AVO_INWIN; // RULE_06
				end
			end
		endcase
	end

	// output is one in over and in-window states
	wire logic next_cmpOut = (next_state == AVO_OVER) ||
		(next_state == AVO_INWIN); // RULE_04

	// sum of the selected inputs
	logic [SUM_W-1:0] sumAll;
	always_comb begin
		sumAll = '0;
		// inputs past the count add nothing
		for (int i = 0; i < NUM_IN; i++) begin
			if (i < int'(cnt)) begin
				sumAll = sumAll + SUM_W'(meas.value[i]); // RULE_11
			end
		end
	end

	// difference operands
	wire logic [MEAS_W-1:0] absAB = avoAbsDiff(meas.value[0],
		meas.value[1]); // RULE_12
	wire logic negAB = meas.value[0] < meas.value[1]; // RULE_13
	wire logic [SUM_W-1:0] meanAll = sumAll / SUM_W'(cnt); // RULE_14

	// math result selection
	wire logic [SUM_W-1:0] next_mathResult = diffMode ? SUM_W'(absAB) :
		avgMode ? meanAll : sumAll;
	// sign only meaningful in difference mode
	wire logic next_mathSign = diffMode && negAB;

	// equality check with anomaly override
	wire logic anyAnomaly = meas.anomaly[0] || meas.anomaly[1];
	wire logic withinTol = absAB <= tol; // RULE_15
	wire logic next_eqOut = withinTol && !(forceFalse && anyAnomaly); // RULE_16

	// status word read back
	wire logic [31:0] statusWord = {26'h0, eqOut, mathSign, cmpOut,
		anyAnomaly, state};

	// read data mux, unmapped reads zero
	wire logic [31:0] next_rdData = !bus.rd ? 32'h0 :
		selCtrl ? {24'h0, ctrl} :
		selThresh ? {16'h0, thresh} :
		selHigh ? {16'h0, highTh} :
		selLow ? {16'h0, lowTh} :
		selTol ? {16'h0, tol} :
		selStatus ? statusWord :
		selResult ? {13'h0, mathResult} : 32'h0;

	// configuration register writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// reset values for every register
			ctrl <= CTRL_RST;
			thresh <= THRESH_RST;
			highTh <= THRESH_RST;
			lowTh <= THRESH_RST;
			tol <= TOL_RST;
		end else if (bus.wr) begin
			// writes to unmapped addresses fall through
			if (selCtrl) ctrl <= bus.wrData[7:0];
			if (selThresh) thresh <= bus.wrData[MEAS_W-1:0];
			if (selHigh) highTh <= bus.wrData[MEAS_W-1:0];
			if (selLow) lowTh <= bus.wrData[MEAS_W-1:0];
			if (selTol) tol <= bus.wrData[MEAS_W-1:0];
		end
	end

	// per-scan evaluation, reset to under threshold
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// under threshold, every result cleared
			state <= AVO_UNDER; // RULE_17
			cmpOut <= 1'b0;
			mathResult <= '0;
			mathSign <= 1'b0;
			eqOut <= 1'b0;
			rdData <= 32'h0;
		end else begin
			// one evaluation per scan
			state <= next_state;
			cmpOut <= next_cmpOut;
			mathResult <= next_mathResult;
			mathSign <= next_mathSign;
			eqOut <= next_eqOut;
			rdData <= next_rdData;
		end
	end

	// assertions, one or two per guarded rule
	// single threshold, under state, value below threshold
	a_under_stays_low: assert property ( // RULE_01
		@(posedge sys_clk) disable iff (rst)
		(!windowEn && state == AVO_UNDER && !atOrOver) |=> !cmpOut)
		else $error("comparator rose below threshold");
	// single threshold, value at or above threshold
	a_at_thresh_high: assert property ( // RULE_02
		@(posedge sys_clk) disable iff (rst)
		(!windowEn && !$past(windowEn) && atOrOver) |=> cmpOut)
		else $error("comparator low at or above threshold");
	// release point moves with the upstream hysteresis
	a_hyst_live: assert property ( // RULE_03
		@(posedge sys_clk) disable iff (rst)
		(!windowEn && state == AVO_OVER && SUM_W'(meas.value[0]) +
		SUM_W'(meas.hysteresis) < SUM_W'(thresh)) |=> !cmpOut)
		else $error("hysteresis from upstream not applied");
	// output register mirrors the state register
	a_out_follows_state: assert property ( // RULE_04
		@(posedge sys_clk) disable iff (rst)
		cmpOut == (state == AVO_OVER || state == AVO_INWIN))
		else $error("comparator output disagrees with state");
	// window mode, inside and leaving the band
	a_win_leave_out: assert property ( // RULE_05
		@(posedge sys_clk) disable iff (rst)
		(windowEn && state == AVO_INWIN && leaveWin) |=>
		(!cmpOut && state == AVO_OUTWIN))
		else $error("window did not go out");
	// window mode, inside and within the band
	a_win_hold_in: assert property ( // RULE_06
		@(posedge sys_clk) disable iff (rst)
		(windowEn && state == AVO_INWIN && !leaveWin) |=> cmpOut)
		else $error("window left while inside");
	// window mode, outside and not in the entry band
	a_win_hold_out: assert property ( // RULE_07
		@(posedge sys_clk) disable iff (rst)
		(windowEn && state == AVO_OUTWIN && !enterWin) |=> !cmpOut)
		else $error("window entered outside band");
	// window mode, outside and in the entry band
	a_win_enter_in: assert property ( // RULE_08
		@(posedge sys_clk) disable iff (rst)
		(windowEn && state == AVO_OUTWIN && enterWin) |=> cmpOut)
		else $error("window not entered");
	// over state above threshold less hysteresis
	a_over_hold: assert property ( // RULE_09
		@(posedge sys_clk) disable iff (rst)
		(!windowEn && state == AVO_OVER && !belowHyst) |=> cmpOut)
		else $error("over state dropped early");
	// over state below threshold less hysteresis
	a_over_release: assert property ( // RULE_10
		@(posedge sys_clk) disable iff (rst)
		(!windowEn && state == AVO_OVER && belowHyst) |=> !cmpOut)
		else $error("over state not released");
	// sum of the first two inputs when the count is two
	a_sum_two: assert property ( // RULE_11
		@(posedge sys_clk) disable iff (rst)
		(!diffMode && !avgMode && cnt == CNT_MIN) |=>
		mathResult == SUM_W'($past(meas.value[0])) +
		SUM_W'($past(meas.value[1])))
		else $error("sum of two wrong");
	// magnitude plus the smaller input gives the larger
	a_diff_mag: assert property ( // RULE_12
		@(posedge sys_clk) disable iff (rst)
		diffMode |=> mathResult + SUM_W'(mathSign ?
		$past(meas.value[0]) : $past(meas.value[1])) ==
		SUM_W'(mathSign ? $past(meas.value[1]) :
		$past(meas.value[0])))
		else $error("difference magnitude wrong");
	// sign follows which input is larger
	a_diff_sign: assert property ( // RULE_13
		@(posedge sys_clk) disable iff (rst)
		diffMode |=>
		mathSign == ($past(meas.value[0]) < $past(meas.value[1])))
		else $error("difference sign wrong");
	// mean times count never exceeds the sum
	a_mean_scale: assert property ( // RULE_14
		@(posedge sys_clk) disable iff (rst)
		(!diffMode && avgMode) |=>
		mathResult * SUM_W'($past(cnt)) <= $past(sumAll))
		else $error("mean above sum over count");
	// remainder of the mean stays below the count
	a_mean_floor: assert property ( // RULE_14
		@(posedge sys_clk) disable iff (rst)
		(!diffMode && avgMode) |=>
		$past(sumAll) - mathResult * SUM_W'($past(cnt)) <
		SUM_W'($past(cnt)))
		else $error("mean below sum over count");
	// healthy inputs within tolerance give equality
	a_eq_within: assert property ( // RULE_15
		@(posedge sys_clk) disable iff (rst)
		(withinTol && !anyAnomaly) |=> eqOut)
		else $error("equality low within tolerance");
	// inputs further apart than tolerance give inequality
	a_eq_outside: assert property ( // RULE_15
		@(posedge sys_clk) disable iff (rst)
		(SUM_W'(meas.value[0]) > SUM_W'(meas.value[1]) + SUM_W'(tol) ||
		SUM_W'(meas.value[1]) > SUM_W'(meas.value[0]) + SUM_W'(tol)) |=>
		!eqOut)
		else $error("equality high outside tolerance");
	// anomaly with force-false set keeps equality low
	a_eq_force: assert property ( // RULE_16
		@(posedge sys_clk) disable iff (rst)
		(forceFalse && anyAnomaly) |=> !eqOut)
		else $error("equality high on anomaly");
	// reset leaves the comparator under threshold
	a_reset_clear: assert property ( // RULE_17
		@(posedge sys_clk)
		rst |=> (state == AVO_UNDER && !cmpOut && !eqOut))
		else $error("reset did not clear state");

	// covers for the main scenarios
	// window entered and left again
	c_win_cycle: cover property (@(posedge sys_clk) disable iff (rst)
		state == AVO_OUTWIN ##1 state == AVO_INWIN ##[1:20]
		state == AVO_OUTWIN);
	// threshold crossed up and back down
	c_thresh_cycle: cover property (@(posedge sys_clk) disable iff (rst)
		state == AVO_UNDER ##1 state == AVO_OVER ##[1:20]
		state == AVO_UNDER);
	// difference with the second input larger
	c_neg_diff: cover property (@(posedge sys_clk) disable iff (rst)
		diffMode && negAB);
	// anomaly forcing equality low
	c_force_false: cover property (@(posedge sys_clk) disable iff (rst)
		forceFalse && anyAnomaly && withinTol);
	// mean taken over all eight inputs
	c_mean_eight: cover property (@(posedge sys_clk) disable iff (rst)
		!diffMode && avgMode && cnt == CNT_MAX);

endmodule : analog_value_operators
`default_nettype wire

// ==== avo_meas_src.sv ====
// upstream measurement source model feeding the operators
`timescale 1ns/10ps
`default_nettype none
module avo_meas_src import avo_pkg::*; (
	input wire logic [NUM_IN-1:0][MEAS_W-1:0] level, // raw values
	input wire logic [MEAS_W-1:0] hyst, // hysteresis kept upstream
	output var avo_meas_t meas // bundle to the operators
);
	// full-scale reading is reported as an anomaly
	logic [NUM_IN-1:0] fullScale;
	for (genvar i = 0; i < NUM_IN; i++) begin : g_fs
		assign fullScale[i] = (level[i] == 16'hFFFF);
	end
	// hysteresis travels with the value, never stored downstream
	assign meas = {level, fullScale, hyst};
endmodule : avo_meas_src
`default_nettype wire

// ==== analog_value_operators_tb_top.sv ====
// self-checking bench for the analog value operators
`timescale 1ns/10ps
`default_nettype none
module analog_value_operators_tb_top import avo_pkg::*;;
	// one row: config, inputs and expected math outputs
	typedef struct {
		logic [7:0] ctrl;
		logic [15:0] tol, a, b;
		logic [SUM_W-1:0] res;
		logic sign, eq;
	} avo_row_t;
	avo_row_t rows[12] = '{
		'{8'h20, 16'h0, 16'h10, 16'h20, 19'h30, 1'b0, 1'b0},
		'{8'h80, 16'h0, 16'hFFFE, 16'hFFFE, 19'h21AFC, 1'b0, 1'b1},
		'{8'h84, 16'h8, 16'h8, 16'h0, 19'h361, 1'b0, 1'b1},
		'{8'h32, 16'h1F, 16'h10, 16'h30, 19'h20, 1'b1, 1'b0},
		'{8'h22, 16'h20, 16'h30, 16'h10, 19'h20, 1'b0, 1'b1},
		'{8'h22, 16'h0, 16'h5, 16'h5, 19'h0, 1'b0, 1'b1},
		'{8'h2A, 16'h0, 16'hFFFF, 16'hFFFF, 19'h0, 1'b0, 1'b0},
		'{8'h22, 16'h0, 16'hFFFF, 16'hFFFF, 19'h0, 1'b0, 1'b1},
		'{8'h30, 16'h0, 16'h1, 16'h2, 19'h203, 1'b0, 1'b0},
		'{8'h34, 16'h0, 16'h2, 16'h0, 19'hAB, 1'b0, 1'b0},
		'{8'h10, 16'h0, 16'h1, 16'h2, 19'h3, 1'b0, 1'b0},
		'{8'hF0, 16'h0, 16'h1, 16'h2, 19'h1B03, 1'b0, 1'b0}
	};
	// threshold sequence: value, hysteresis, expected output
	logic [15:0] thrV[8] = '{16'hFF, 16'h100, 16'hF0, 16'hEF, 16'hFF,
		16'h101, 16'hE5, 16'hFF};
	logic [15:0] thrH[8] = '{16'h10, 16'h10, 16'h10, 16'h10, 16'h10,
		16'h10, 16'h20, 16'h0};
	logic thrE[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	// window sequence with hysteresis 0x10, high 0x200, low 0x100
	logic [15:0] winV[8] = '{16'h1F8, 16'hFF, 16'h100, 16'h200, 16'hF0,
		16'hEF, 16'h1F0, 16'h201};
	logic winE[8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	logic sys_clk, rst; // clock and reset
	avo_bus_t bus; // register port request
	logic [NUM_IN-1:0][MEAS_W-1:0] level; // upstream raw values
	logic [MEAS_W-1:0] hyst; // upstream hysteresis
	avo_meas_t meas; // measurement bundle
	logic [31:0] rdData, d; // read data, last read
	logic cmpOut, mathSign, eqOut; // logic outputs
	logic [SUM_W-1:0] mathResult; // math output
	int nFail = 0, nTests = 0; // counters
	avo_meas_src u_src (.level(level), .hyst(hyst), .meas(meas));
	analog_value_operators u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus),
		.meas(meas), .rdData(rdData), .cmpOut(cmpOut),
		.mathResult(mathResult), .mathSign(mathSign), .eqOut(eqOut));
	// verdict and end of run
	task automatic stopTest();
		if (nFail == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stopTest
	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle register write
	task automatic busWr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		bus.addr <= a;
		bus.wrData <= v;
		bus.wr <= 1'b1;
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask : busWr
	// one-cycle register read, data taken in the following cycle
	task automatic busRd(input logic [7:0] a);
		@(posedge sys_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1;
		d = rdData;
	endtask : busRd
	// apply one measurement, look after the evaluating edge
	task automatic step(input logic [15:0] v, input logic [15:0] h);
		@(posedge sys_clk);
		level[0] <= v;
		hyst <= h;
		@(posedge sys_clk);
		#1;
	endtask : step
	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// hang guard
	initial begin
		#100000;
		nFail++;
		stopTest();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		bus = '0;
		hyst = 16'h10;
		for (int i = 0; i < NUM_IN; i++) begin
			level[i] = MEAS_W'(16'h0100 * i);
		end
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk({28'h0, cmpOut, mathSign, eqOut, rdData[0]}, 32'h0);
		// ordinary math and equality cases
		foreach (rows[i]) begin
			busWr(OFS_CTRL, {24'h0, rows[i].ctrl});
			busWr(OFS_TOL, {16'h0, rows[i].tol});
			@(posedge sys_clk);
			level[0] <= rows[i].a;
			level[1] <= rows[i].b;
			@(posedge sys_clk);
			#1;
			chk({13'h0, mathResult}, {13'h0, rows[i].res});
			chk({31'h0, mathSign}, {31'h0, rows[i].sign});
			chk({31'h0, eqOut}, {31'h0, rows[i].eq});
			busRd(OFS_RESULT);
			chk(d, {13'h0, rows[i].res});
		end
		// threshold comparator with live hysteresis
		busWr(OFS_CTRL, 32'h20);
		busWr(OFS_THRESH, 32'h100);
		foreach (thrV[i]) begin
			step(thrV[i], thrH[i]);
			chk({31'h0, cmpOut}, {31'h0, thrE[i]});
		end
		// window comparator
		busWr(OFS_HIGH, 32'h200);
		busWr(OFS_LOW, 32'h100);
		busWr(OFS_CTRL, 32'h21);
		foreach (winV[i]) begin
			step(winV[i], 16'h10);
			chk({31'h0, cmpOut}, {31'h0, winE[i]});
		end
		step(16'h150, 16'h10);
		busRd(OFS_STATUS);
		chk({28'h0, d[3:0]}, 32'hA);
		// read-back, unmapped place, then reset in mid-run
		busRd(OFS_THRESH);
		chk(d, 32'h100);
		busRd(8'h1C);
		chk(d, 32'h0);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk({29'h0, cmpOut, eqOut, |mathResult}, 32'h0);
		busRd(OFS_CTRL);
		chk(d, 32'h20);
		busRd(OFS_THRESH);
		chk(d, 32'h0);
		stopTest();
	end
endmodule : analog_value_operators_tb_top
`default_nettype wire
